//--- hw/topwm_timer.sv
`timescale 1ns/10ps

// Contract
// R1: Trigger reloads FFFCh, captures FFFDh, sets flag.
// R2: Trigger capture flag can request interrupt.
// R3: Flag clears after status read then low access.
// R4: One-pulse match drives after-pulse level.
// R5: Pin holds pulse level, then after level.
// R6: One-pulse never sets first match flag.
// R7: PWM bit overrides one-pulse bit.
// R8: Equal levels give a constant pin.
// R9: Second capture works; trigger still resets counter.
// R10: Second compare flags time; drives the second pin in free mode only.
// R11: PWM compare values load at period end.
// R12: PWM second match reloads FFFCh.
// R13: PWM matches drive first, then second level.
// R14: Positive pulse spans second minus first value.
// R15: PWM sets neither match flag.
// R16: PWM second match sets first capture flag.
// R17: PWM disconnects trigger pin; second capture works.
// R18: High-byte compare write inhibits until low write.
// R19: Compare value gives value plus five ticks.
// R20: Halt freezes counter; resumes after wake.
// R21: Capture edge in halt is taken at exit.
// R22: One request, grouped enables; not halt wake.
// R23: One-pulse trigger edge polarity is selectable.
// R24: Tick source is div4, div2, div8, external.
// R25: Pin enable only routes waveform to pin.
module topwm_timer
  import topwm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_trigger_input_pin,
  input wire logic i_second_capture_pin,
  input wire logic i_ext_tick,
  input wire logic i_halt,
  input wire logic i_irq_mask,
  output logic o_waveform_output_pin,
  output logic o_waveform_output_pin_oe,
  output logic o_match_b_pin,
  output logic o_match_b_pin_oe,
  output logic o_timer_irq
);

  // ==========================================================
  // State.
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic timd_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic [15:0] cmp1_act_q;
  logic [15:0] cmp2_act_q;
  logic [1:0] inhibit_q;
  logic [15:0] cnt_q;
  logic [2:0] presc_q;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic [4:0] flag_q;
  logic [4:0] arm_q;
  logic [4:0] snap_q;
  logic halt_prev_q;
  logic hold_a_q;
  logic hold_b_q;
  logic trig_prev_q;
  logic cap2_prev_q;
  logic ext_prev_q;
  logic wave_q;
  logic wave_oe_q;
  logic pin2_q;
  logic pin2_oe_q;
  logic irq_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] rd_d;

  topwm_mode_t mode;
  logic acc;
  logic wr;
  logic rd;
  logic trig_edge;
  logic cap2_edge;
  logic ext_edge;
  logic tick;
  logic [2:0] div_mask;
  logic m1;
  logic m2;
  logic halt_exit;
  logic opm_trig;
  logic capture1_now;
  logic capture2_now;
  logic pwm_wrap;
  logic [4:0] set_v;
  logic [4:0] clr_v;

  // Detects the selected edge between two samples of a pin.
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rise);
    return rise ? (!prev && cur) : (prev && !cur);
  endfunction

  // True on the committing cycle of an access to one offset.
  function automatic logic hit(input logic [5:0] ofs, input logic a,
                               input logic [5:0] addr);
    return a && (addr == ofs);
  endfunction

  // ==========================================================
  // Bus handshake and decode.
  // A request is answered one edge after it is first seen.
  assign acc = !wait_q && (i_avs_read || i_avs_write);
  assign wr = acc && i_avs_write && i_avs_byteenable[0];
  assign rd = acc && i_avs_read;

  // Waitrequest drops for exactly one cycle per access.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_q <= 1'b1;
    end else if (wait_q && (i_avs_read || i_avs_write)) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_d = 8'h00;
    unique case (i_avs_address)
      OFS_CTRL_FIRST: rd_d = ctl1_q;
      OFS_CTRL_SECOND: rd_d = ctl2_q;
      OFS_FLAGS: rd_d = {flag_q[F_CAP_A], flag_q[F_MATCH_A],
                         flag_q[F_WRAP], flag_q[F_CAP_B],
                         flag_q[F_MATCH_B], timd_q, 2'h0};
      OFS_CMP1_HI: rd_d = cmp1_q[15:8];
      OFS_CMP1_LO: rd_d = cmp1_q[7:0];
      OFS_CMP2_HI: rd_d = cmp2_q[15:8];
      OFS_CMP2_LO: rd_d = cmp2_q[7:0];
      OFS_CAP1_HI: rd_d = cap1_q[15:8];
      OFS_CAP1_LO: rd_d = cap1_q[7:0];
      OFS_CAP2_HI: rd_d = cap2_q[15:8];
      OFS_CAP2_LO: rd_d = cap2_q[7:0];
      OFS_CNT_HI: rd_d = cnt_q[15:8];
      OFS_CNT_LO: rd_d = cnt_q[7:0];
      default: rd_d = 8'h00;
    endcase
  end

  // Read data and the flag snapshot that software actually sees.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 32'h0000_0000;
      snap_q <= 5'h00;
    end else if (wait_q && i_avs_read) begin
      rdata_q <= {24'h00_0000, rd_d};
      snap_q <= flag_q;
    end
  end

  // ==========================================================
  // Control registers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctl1_q <= CTRL_RST;
      ctl2_q <= CTRL_RST;
      timd_q <= 1'b0;
    end else if (wr) begin
      if (i_avs_address == OFS_CTRL_FIRST) begin
        ctl1_q <= i_avs_writedata[7:0];
      end
      if (i_avs_address == OFS_CTRL_SECOND) begin
        ctl2_q <= i_avs_writedata[7:0];
      end
      if (i_avs_address == OFS_FLAGS) begin
        timd_q <= i_avs_writedata[2];
      end
    end
  end

  // Mode resolution; PWM wins when both bits are set.
  always_comb begin
    if (ctl2_q[B_PWM]) begin
      mode = TOPWM_PWM; // see R7
    end else if (ctl2_q[B_ONE_PULSE]) begin
      mode = TOPWM_ONE;
    end else begin
      mode = TOPWM_FREE;
    end
  end

  // ==========================================================
  // Tick generation.
  // Prescaler mask per source; external ticks use edges.
  always_comb begin
    unique case (ctl2_q[B_TICK_LO +: 2])
      TICK_DIV2: div_mask = MASK_DIV2; // see R24
      TICK_DIV8: div_mask = MASK_DIV8;
      default: div_mask = MASK_DIV4;
    endcase
  end

  assign ext_edge = edge_hit(ext_prev_q, i_ext_tick, ctl2_q[B_EXT_EDGE]);
  // Halt and timer disable both stop the tick.
  assign tick = !i_halt && !timd_q &&
                ((ctl2_q[B_TICK_LO +: 2] == TICK_EXT) ? ext_edge
                 : ((presc_q & div_mask) == div_mask)); // see R20

  // Prescaler runs freely unless halted or disabled.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      presc_q <= 3'h0;
    end else if (!i_halt && !timd_q) begin
      presc_q <= presc_q + 3'h1;
    end
  end

  // Pin history used for edge detection.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      trig_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= i_trigger_input_pin;
      cap2_prev_q <= i_second_capture_pin;
      ext_prev_q <= i_ext_tick;
      halt_prev_q <= i_halt;
    end
  end

  // ==========================================================
  // Events.
  assign trig_edge = edge_hit(trig_prev_q, i_trigger_input_pin,
                              ctl1_q[B_TRIG_POL]); // see R23
  assign cap2_edge = edge_hit(cap2_prev_q, i_second_capture_pin,
                              ctl2_q[B_EDGE2]);
  assign halt_exit = halt_prev_q && !i_halt;
  // Matches are taken on the tick that leaves the matching count.
  assign m1 = tick && (cnt_q == cmp1_act_q) && !inhibit_q[0]; // see R19
  assign m2 = tick && (cnt_q == cmp2_act_q) && !inhibit_q[1];
  assign pwm_wrap = (mode == TOPWM_PWM) && m2;
  assign opm_trig = (mode == TOPWM_ONE) && trig_edge &&
                    !i_halt && !timd_q; // see R1
  // The trigger pin captures the count only in free mode.
  assign capture1_now = (mode == TOPWM_FREE) &&
                        ((trig_edge && !i_halt) ||
                         (halt_exit && hold_a_q)); // see R17
  assign capture2_now = (cap2_edge && !i_halt) ||
                        (halt_exit && hold_b_q); // see R9

  // Edges seen during halt stay armed until the wake-up.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hold_a_q <= 1'b0;
      hold_b_q <= 1'b0;
    end else if (halt_exit) begin
      hold_a_q <= 1'b0;
      hold_b_q <= 1'b0;
    end else if (i_halt) begin
      hold_a_q <= hold_a_q || ((mode == TOPWM_FREE) && trig_edge);
      hold_b_q <= hold_b_q || cap2_edge; // see R21
    end
  end

  // ==========================================================
  // Free-running counter.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_q <= CNT_RST;
    end else if (opm_trig || pwm_wrap) begin
      cnt_q <= CNT_RELOAD; // see R12
    end else if (wr && (i_avs_address == OFS_CNT_LO)) begin
      cnt_q <= CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Compare registers, inhibit and the PWM shadow copies.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmp1_q <= CMP_RST;
      cmp2_q <= CMP_RST;
      inhibit_q <= 2'h0;
    end else if (wr) begin
      unique case (i_avs_address)
        OFS_CMP1_HI: begin
          cmp1_q[15:8] <= i_avs_writedata[7:0];
          inhibit_q[0] <= 1'b1; // see R18
        end
        OFS_CMP1_LO: begin
          cmp1_q[7:0] <= i_avs_writedata[7:0];
          inhibit_q[0] <= 1'b0;
        end
        OFS_CMP2_HI: begin
          cmp2_q[15:8] <= i_avs_writedata[7:0];
          inhibit_q[1] <= 1'b1;
        end
        OFS_CMP2_LO: begin
          cmp2_q[7:0] <= i_avs_writedata[7:0];
          inhibit_q[1] <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // In PWM the active values change only at the period end.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmp1_act_q <= CMP_RST;
      cmp2_act_q <= CMP_RST;
    end else if ((mode != TOPWM_PWM) || m2) begin
      cmp1_act_q <= cmp1_q; // see R11
      cmp2_act_q <= cmp2_q;
    end
  end

  // ==========================================================
  // Capture registers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end else begin
      if (opm_trig) begin
        cap1_q <= OPM_CAPT; // see R1
      end else if (capture1_now) begin
        cap1_q <= cnt_q;
      end
      if (capture2_now) begin
        cap2_q <= cnt_q; // see R21
      end
    end
  end

  // ==========================================================
  // Flags and their two-step clear.
  always_comb begin
    set_v = 5'h00;
    set_v[F_CAP_A] = capture1_now || opm_trig || pwm_wrap; // see R16
    set_v[F_MATCH_A] = m1 && (mode == TOPWM_FREE); // see R6
    set_v[F_WRAP] = tick && (cnt_q == CNT_TOP) && !pwm_wrap;
    set_v[F_CAP_B] = capture2_now;
    set_v[F_MATCH_B] = m2 && (mode != TOPWM_PWM); // see R15
    clr_v = 5'h00;
    clr_v[F_CAP_A] = hit(OFS_CAP1_LO, acc, i_avs_address);
    clr_v[F_MATCH_A] = hit(OFS_CMP1_LO, acc, i_avs_address);
    clr_v[F_WRAP] = hit(OFS_CNT_LO, acc, i_avs_address);
    clr_v[F_CAP_B] = hit(OFS_CAP2_LO, acc, i_avs_address);
    clr_v[F_MATCH_B] = hit(OFS_CMP2_LO, acc, i_avs_address);
    clr_v = clr_v & arm_q; // see R3
  end

  // A set in the clearing cycle wins over the clear.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      flag_q <= 5'h00;
    end else begin
      flag_q <= (flag_q & ~clr_v) | set_v;
    end
  end

  // Status reads arm the clear for each flag seen set.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      arm_q <= 5'h00;
    end else if (rd && (i_avs_address == OFS_FLAGS)) begin
      arm_q <= (arm_q & ~clr_v) | snap_q; // see R3
    end else begin
      arm_q <= arm_q & ~clr_v;
    end
  end

  // ==========================================================
  // Waveform pins; the enable only routes the level out.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wave_q <= 1'b0;
      pin2_q <= 1'b0;
    end else begin
      if (opm_trig) begin
        wave_q <= ctl1_q[B_LEVEL_B]; // see R5
      end else if (pwm_wrap) begin
        wave_q <= ctl1_q[B_LEVEL_B]; // see R13
      end else if (m1) begin
        wave_q <= ctl1_q[B_LEVEL_A]; // see R4, see R14, see R8
      end
      if ((mode == TOPWM_FREE) && m2) begin
        pin2_q <= ctl1_q[B_LEVEL_B]; // see R10
      end
    end
  end

  // Output enables follow the pin enables and timer disable; the second also needs free mode.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wave_oe_q <= 1'b0;
      pin2_oe_q <= 1'b0;
    end else begin
      wave_oe_q <= ctl2_q[B_PIN_EN] && !timd_q; // see R25
      pin2_oe_q <= ctl2_q[B_PIN2_EN] && !timd_q &&
                   (mode == TOPWM_FREE);
    end
  end

  // One shared request gated by group enables and the mask.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !i_irq_mask &&
        ((ctl1_q[B_CAP_IE] && (flag_q[F_CAP_A] || flag_q[F_CAP_B])) ||
         (ctl1_q[B_MATCH_IE] &&
          (flag_q[F_MATCH_A] || flag_q[F_MATCH_B])) ||
         (ctl1_q[B_WRAP_IE] && flag_q[F_WRAP])); // see R2, see R22
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_waveform_output_pin = wave_q;
  assign o_waveform_output_pin_oe = wave_oe_q;
  assign o_match_b_pin = pin2_q;
  assign o_match_b_pin_oe = pin2_oe_q;
  assign o_timer_irq = irq_q;

  // ==========================================================
  // Checks.
  AST_OPM_TRIGGER: assert property (@(posedge i_clk) // see R1
    disable iff (!i_reset_n) opm_trig |=>
    (cnt_q == CNT_RELOAD) && (cap1_q == OPM_CAPT) && flag_q[F_CAP_A])
    else $error("one-pulse trigger did not reload and capture");
  AST_OPM_LEVEL: assert property (@(posedge i_clk) // see R5
    disable iff (!i_reset_n) opm_trig |=> wave_q == ctl1_q[B_LEVEL_B])
    else $error("pulse level not driven after trigger");
  AST_PWM_RELOAD: assert property (@(posedge i_clk) // see R12
    disable iff (!i_reset_n) pwm_wrap |=>
    (cnt_q == CNT_RELOAD) && flag_q[F_CAP_A])
    else $error("PWM period end did not reload counter");
  AST_MATCH_A_FREE: assert property (@(posedge i_clk) // see R6
    disable iff (!i_reset_n)
    $rose(flag_q[F_MATCH_A]) |-> $past(mode) == TOPWM_FREE)
    else $error("first match flag set outside free mode");
  AST_MATCH_B_PWM: assert property (@(posedge i_clk) // see R15
    disable iff (!i_reset_n)
    $rose(flag_q[F_MATCH_B]) |-> $past(mode) != TOPWM_PWM)
    else $error("second match flag set in PWM mode");
  AST_HALT_FROZEN: assert property (@(posedge i_clk) // see R20
    disable iff (!i_reset_n)
    i_halt && !wr |=> cnt_q == $past(cnt_q))
    else $error("counter moved during halt");
  AST_INHIBIT: assert property (@(posedge i_clk) // see R18
    disable iff (!i_reset_n)
    wr && (i_avs_address == OFS_CMP1_HI) |=> ##1 !m1)
    else $error("compare ran after high byte write");
  AST_CLEAR_ARMED: assert property (@(posedge i_clk) // see R3
    disable iff (!i_reset_n)
    $fell(flag_q[F_CAP_A]) |-> $past(arm_q[F_CAP_A]))
    else $error("capture flag cleared without status read");
  AST_IRQ: assert property (@(posedge i_clk) // see R22
    disable iff (!i_reset_n)
    flag_q[F_CAP_A] && ctl1_q[B_CAP_IE] && !i_irq_mask |=> o_timer_irq)
    else $error("capture interrupt not requested");
  AST_PIN_OE: assert property (@(posedge i_clk) // see R25
    disable iff (!i_reset_n)
    !ctl2_q[B_PIN_EN] |=> !o_waveform_output_pin_oe)
    else $error("pin driven while routing disabled");

endmodule

//--- include/topwm_pkg.sv
package topwm_pkg;

  // ==========================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_CTRL_FIRST = 6'h00;
  localparam logic [5:0] OFS_CTRL_SECOND = 6'h04;
  localparam logic [5:0] OFS_FLAGS = 6'h08;
  localparam logic [5:0] OFS_CMP1_HI = 6'h0c;
  localparam logic [5:0] OFS_CMP1_LO = 6'h10;
  localparam logic [5:0] OFS_CMP2_HI = 6'h14;
  localparam logic [5:0] OFS_CMP2_LO = 6'h18;
  localparam logic [5:0] OFS_CAP1_HI = 6'h1c;
  localparam logic [5:0] OFS_CAP1_LO = 6'h20;
  localparam logic [5:0] OFS_CAP2_HI = 6'h24;
  localparam logic [5:0] OFS_CAP2_LO = 6'h28;
  localparam logic [5:0] OFS_CNT_HI = 6'h2c;
  localparam logic [5:0] OFS_CNT_LO = 6'h30;

  // ==========================================================
  // Field positions of the first control register.
  localparam int B_CAP_IE = 7;
  localparam int B_MATCH_IE = 6;
  localparam int B_WRAP_IE = 5;
  localparam int B_LEVEL_B = 2;
  localparam int B_TRIG_POL = 1;
  localparam int B_LEVEL_A = 0;
  // Field positions of the second control register.
  localparam int B_PIN_EN = 7;
  localparam int B_PIN2_EN = 6;
  localparam int B_ONE_PULSE = 5;
  localparam int B_PWM = 4;
  localparam int B_TICK_LO = 2;
  localparam int B_EDGE2 = 1;
  localparam int B_EXT_EDGE = 0;
  // Index of each flag inside the internal flag vector.
  localparam int F_CAP_A = 0;
  localparam int F_MATCH_A = 1;
  localparam int F_WRAP = 2;
  localparam int F_CAP_B = 3;
  localparam int F_MATCH_B = 4;

  // ==========================================================
  // Reset and reload values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_RST = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] OPM_CAPT = 16'hfffd;
  localparam logic [15:0] CNT_TOP = 16'hffff;

  // ==========================================================
  // Tick source encodings and prescaler masks.
  localparam logic [1:0] TICK_DIV4 = 2'h0;
  localparam logic [1:0] TICK_DIV2 = 2'h1;
  localparam logic [1:0] TICK_DIV8 = 2'h2;
  localparam logic [1:0] TICK_EXT = 2'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  // Operating mode after the pulse and PWM bits are resolved.
  typedef enum logic [1:0] {TOPWM_FREE, TOPWM_ONE, TOPWM_PWM} topwm_mode_t;

endpackage

//--- test/topwm_partner.sv
`timescale 1ns/10ps

// ==========================================
// Far-side model: trigger edge source and external tick source.
module topwm_partner (
  input wire logic i_clk,
  output logic o_trigger,
  output logic o_tick
);
  // Both lines rest low until a task moves them.
  initial begin
    o_trigger = 1'b0;
    o_tick = 1'b0;
  end

  // Rising tick edges, each level held three cycles so none is missed.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk) o_tick <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_tick <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask

  // Moves the trigger to a level; the edge kind follows from the old one.
  task automatic trig(input logic lvl);
    @(posedge i_clk) o_trigger <= lvl;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

//--- test/topwm_timer_tb.sv
`timescale 1ns/10ps

// ==========================================
// Self-checking bench for the pulse and PWM timer.
module topwm_timer_tb;
  import topwm_pkg::*;
  logic clk;
  logic reset_n;
  logic [5:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_rq;
  logic trig;
  logic ext_tick;
  logic cap2;
  logic halt;
  logic irq_mask;
  logic wave;
  logic wave_oe;
  logic irq;
  logic pin2;
  logic pin2_oe;
  logic [3:0] be;
  int fail_count;
  int cmp_count;

  topwm_timer topwm_timer_inst (
    .i_clk(clk), .i_reset_n(reset_n), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_rq), .i_trigger_input_pin(trig),
    .i_second_capture_pin(cap2), .i_ext_tick(ext_tick), .i_halt(halt),
    .i_irq_mask(irq_mask), .o_waveform_output_pin(wave),
    .o_waveform_output_pin_oe(wave_oe), .o_match_b_pin(pin2),
    .o_match_b_pin_oe(pin2_oe), .o_timer_irq(irq));

  topwm_partner topwm_partner_inst (
    .i_clk(clk), .o_trigger(trig), .o_tick(ext_tick));

  // ==========================================
  // Clock at 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one result and counts it.
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {{3{~d}}, d};
    rd_en <= !w;
    wr_en <= w;
    @(posedge clk);
    while (wait_rq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) chk("waitrequest", 8'h00, 8'h01);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  // Register write and masked register read with compare.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string w);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(w, e, q & m);
  endtask

  // Single-bit output compares.
  task automatic pin(input logic e, input string w);
    chk(w, {7'h00, e}, {7'h00, wave});
  endtask

  task automatic irq_is(input logic e);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask

  // ==========================================
  // Reset values and an unmapped read.
  task automatic t_reset();
    rd(OFS_CTRL_FIRST, 8'hff, CTRL_RST, "ctrl_first");
    rd(OFS_CMP1_HI, 8'hff, CMP_RST[15:8], "cmp1_hi");
    rd(OFS_CMP2_LO, 8'hff, CMP_RST[7:0], "cmp2_lo");
    rd(6'h3c, 8'hff, 8'h00, "unmapped");
    // A write without its low byte lane enabled must be ignored.
    be <= 4'he;
    wr(OFS_CTRL_FIRST, 8'h5a);
    be <= 4'hf;
    rd(OFS_CTRL_FIRST, 8'hff, CTRL_RST, "be_ignored");
    $display("test reset done");
  endtask

  // Triggered pulses, flag clearing, polarity and compare inhibit.
  task automatic t_one_pulse();
    wr(OFS_CMP1_HI, 8'h00);
    wr(OFS_CMP1_LO, 8'h03);
    wr(OFS_CTRL_FIRST, 8'h86);
    wr(OFS_CTRL_SECOND, 8'hed);
    topwm_partner_inst.trig(1'b1);
    pin(1'b1, "pulse_level");
    chk("pin_oe", 8'h01, {7'h00, wave_oe});
    chk("pin2_oe_opm", 8'h00, {7'h00, pin2_oe});
    rd(OFS_FLAGS, 8'hc0, 8'h80, "flags_trig");
    irq_is(1'b1);
    rd(OFS_CAP1_HI, 8'hff, OPM_CAPT[15:8], "cap1_hi");
    rd(OFS_CAP1_LO, 8'hff, OPM_CAPT[7:0], "cap1_lo");
    rd(OFS_FLAGS, 8'h80, 8'h00, "flags_clr");
    irq_is(1'b0);
    topwm_partner_inst.tick(7);
    pin(1'b1, "pulse_held");
    topwm_partner_inst.tick(1);
    pin(1'b0, "pulse_end");
    rd(OFS_FLAGS, 8'h40, 8'h00, "match_a_opm");
    topwm_partner_inst.trig(1'b0);
    pin(1'b0, "wrong_edge");
    wr(OFS_CTRL_FIRST, 8'h84);
    topwm_partner_inst.trig(1'b1);
    topwm_partner_inst.trig(1'b0);
    pin(1'b1, "falling_trig");
    wr(OFS_CMP1_HI, 8'h00);
    topwm_partner_inst.tick(8);
    pin(1'b1, "inhibited");
    wr(OFS_CMP1_LO, 8'h06);
    topwm_partner_inst.tick(2);
    pin(1'b1, "before_match");
    topwm_partner_inst.tick(1);
    pin(1'b0, "after_match");
    $display("test one pulse done");
  endtask

  // Period 11 ticks; first compare rewritten mid-period.
  task automatic t_pwm();
    logic [7:0] q;
    int k;
    int c1;
    bus(1'b0, OFS_FLAGS, 8'h00, q);
    bus(1'b0, OFS_CAP1_LO, 8'h00, q);
    wr(OFS_CMP1_LO, 8'h02);
    wr(OFS_CMP2_HI, 8'h00);
    wr(OFS_CMP2_LO, 8'h06);
    wr(OFS_CTRL_FIRST, 8'h81);
    wr(OFS_CTRL_SECOND, 8'hbd);
    wr(OFS_CNT_LO, 8'h00);
    for (int t = 1; t <= 44; t++) begin
      k = (t - 1) % 11 + 1;
      c1 = (t > 33) ? 4 : 2;
      topwm_partner_inst.tick(1);
      if (t == 24) begin
        wr(OFS_CMP1_HI, 8'h00);
        wr(OFS_CMP1_LO, 8'h04);
      end
      if (t == 3) topwm_partner_inst.trig(1'b1);
      if (t == 14) topwm_partner_inst.trig(1'b0);
      pin(k >= c1 + 5 && k < 11, "pwm_pin");
    end
    rd(OFS_FLAGS, 8'hc8, 8'h80, "pwm_flags");
    irq_is(1'b1);
    @(posedge clk) irq_mask <= 1'b1;
    repeat (3) @(posedge clk);
    irq_is(1'b0);
    @(posedge clk) irq_mask <= 1'b0;
    // Equal levels: after one period the pin must stay high.
    wr(OFS_CTRL_FIRST, 8'h85);
    topwm_partner_inst.tick(11);
    for (int t = 0; t < 11; t++) begin
      topwm_partner_inst.tick(1);
      pin(1'b1, "pwm_const");
    end
    $display("test pwm done");
  endtask

  // Halt freezes the count; a capture edge in halt lands at exit.
  task automatic t_halt();
    wr(OFS_CTRL_SECOND, 8'h4f);
    wr(OFS_CNT_LO, 8'h00);
    chk("pin_oe_off", 8'h00, {7'h00, wave_oe});
    chk("pin2_oe_free", 8'h01, {7'h00, pin2_oe});
    @(posedge clk) halt <= 1'b1;
    topwm_partner_inst.tick(3);
    @(posedge clk) cap2 <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_FLAGS, 8'h10, 8'h00, "capb_halt");
    @(posedge clk) halt <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFS_FLAGS, 8'h10, 8'h10, "capb_wake");
    rd(OFS_CAP2_LO, 8'hff, 8'hfc, "cap2_lo");
    rd(OFS_CNT_LO, 8'hff, 8'hfc, "cnt_held");
    topwm_partner_inst.tick(1);
    rd(OFS_CNT_LO, 8'hff, 8'hfd, "cnt_resume");
    // Second compare pin takes its level on the tick leaving 0006h.
    wr(OFS_CTRL_FIRST, 8'h04);
    topwm_partner_inst.tick(9);
    chk("pin2_before", 8'h00, {7'h00, pin2});
    topwm_partner_inst.tick(1);
    chk("pin2_match", 8'h01, {7'h00, pin2});
    $display("test halt done");
  endtask

  // Counts ticks over 16 clocks for one prescaler setting.
  task automatic t_div(input logic [1:0] sel, input logic [7:0] e);
    logic [7:0] q1;
    logic [7:0] q2;
    wr(OFS_CTRL_SECOND, {4'h0, sel, 2'h0});
    bus(1'b0, OFS_CNT_LO, 8'h00, q1);
    repeat (13) @(posedge clk);
    bus(1'b0, OFS_CNT_LO, 8'h00, q2);
    chk("tick_rate", e, q2 - q1);
    $display("test divider done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence after a three-cycle reset.
  initial begin
    fail_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    addr = 6'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h00000000;
    be = 4'hf;
    cap2 = 1'b0;
    halt = 1'b0;
    irq_mask = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_one_pulse();
    t_pwm();
    t_halt();
    t_div(TICK_DIV2, 8'h08);
    t_div(TICK_DIV4, 8'h04);
    t_div(TICK_DIV8, 8'h02);
    results();
  end

  // Cuts a hang short well beyond the expected run of under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
